// ==== core/sci_consts.svh ====
// Constants for the national bit six change interrupt block.
// Assumes a 32-bit AXI4-Lite slave with 8-bit byte addresses.
// Operation
// - Enable bit 4 lets entry into and exit from 1010 raise the interrupt.
// - Enable bit 3 lets entry into and exit from 1000 raise the interrupt.
// - Enable bit 2 lets entry into and exit from 001x raise the interrupt.
// - The 001x compare looks only at the three upper bits.
// - Enable bit 1 lets entry into any undecoded value raise the interrupt.
// - With bit 1 clear, undecoded values never raise the interrupt.
// - Enable bit 0 lets entry into and exit from 0000 raise the interrupt.
// - Status bits latch on their event and clear when software reads them.
`ifndef SCI_CONSTS_SVH
`define SCI_CONSTS_SVH

// Register indices as printed, byte address is four times the index
`define SCI_STATUS_IDX 8'h0c
`define SCI_ENABLE_IDX 8'h0d
`define SCI_STATUS_ADDR 8'h30
`define SCI_ENABLE_ADDR 8'h34
`define SCI_ADDR_W 8
`define SCI_EV_W 5

// Field positions, shared by status and enable
`define SCI_BIT_0000 0
`define SCI_BIT_OTHER 1
`define SCI_BIT_001X 2
`define SCI_BIT_1000 3
`define SCI_BIT_1010 4

// Reset values and bus answers
`define SCI_ENABLE_RST 5'h00
`define SCI_RESP_OKAY 2'h0
`define SCI_RESP_SLVERR 2'h2

`endif

// ==== core/sci_pkg.sv ====
// Types for the national bit six change interrupt block.
// Assumes sci_consts.svh is on the include path.
`include "sci_consts.svh"

package sci_pkg;

    // Whole state of the top module
    typedef struct packed {
        logic aw_held;
        logic [`SCI_ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [`SCI_EV_W-1:0] enable;
        logic [`SCI_EV_W-1:0] status;
        logic [`SCI_EV_W-1:0] prev_match;
        logic primed;
        logic irq;
    } sci_state_type;

    typedef logic [`SCI_EV_W-1:0] sci_vec_type;

endpackage

// ==== core/sci_top.sv ====
// Change interrupt logic for the debounced national bit six nibble.
// Assumes the nibble arrives already debounced and synchronous to aclk.
`timescale 1ns/1ps
`include "sci_consts.svh"

module sci_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Debounced national bit six nibble, bit 3 received first
    input wire logic [3:0] national_bit_six,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [`SCI_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [`SCI_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Level interrupt
    output logic irq
);
    import sci_pkg::*;

    sci_state_type r;
    sci_state_type next_r;
    sci_pkg::sci_vec_type match;
    // Driven bit by bit from the generate loop, so a net rather than a variable
    wire sci_pkg::sci_vec_type event_hit;
    logic write_fire;
    logic read_fire;
    logic status_read;

    // Pattern decode of the current nibble
    always_comb begin
        match = '0;
        match[`SCI_BIT_0000] = (national_bit_six == 4'h0);
        match[`SCI_BIT_001X] = (national_bit_six[3:1] == 3'h1);
        match[`SCI_BIT_1000] = (national_bit_six == 4'h8);
        match[`SCI_BIT_1010] = (national_bit_six == 4'ha);
        // Anything the decoders above do not claim
        match[`SCI_BIT_OTHER] = (national_bit_six != 4'h0)
            && (national_bit_six[3:1] != 3'h1)
            && (national_bit_six != 4'h8)
            && (national_bit_six != 4'ha);
    end

    // One change detector per pattern; the undecoded case fires on entry only
    genvar gi;
    generate
        for (gi = 0; gi < `SCI_EV_W; gi++) begin : g_detect
            if (gi == `SCI_BIT_OTHER) begin : g_entry
                assign event_hit[gi] = r.primed && match[gi] && !r.prev_match[gi];
            end else begin : g_change
                assign event_hit[gi] = r.primed && (match[gi] != r.prev_match[gi]);
            end
        end
    endgenerate

    // Bus strobes
    assign write_fire = r.aw_held && r.w_held && !r.bvalid;
    assign read_fire = arvalid && r.arready;
    assign status_read = read_fire && (araddr == `SCI_STATUS_ADDR);

    // Next state
    always_comb begin
        next_r = r;
        // First cycle after reset only loads history, so reset is no change
        next_r.prev_match = match;
        next_r.primed = 1'b1;
        // Write address and data are taken in either order
        if (awvalid && r.awready) begin
            next_r.aw_held = 1'b1;
            next_r.aw_addr = awaddr;
        end
        if (wvalid && r.wready) begin
            next_r.w_held = 1'b1;
            next_r.w_data = wdata[7:0];
            next_r.w_lane0 = wstrb[0];
        end
        if (r.bvalid && bready) begin
            next_r.bvalid = 1'b0;
        end
        // Register write once both halves are held
        if (write_fire) begin
            next_r.aw_held = 1'b0;
            next_r.w_held = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = `SCI_RESP_OKAY;
            if (r.aw_addr == `SCI_ENABLE_ADDR) begin
                if (r.w_lane0) begin
                    next_r.enable = r.w_data[`SCI_EV_W-1:0];
                end
            end else if (r.aw_addr != `SCI_STATUS_ADDR) begin
                next_r.bresp = `SCI_RESP_SLVERR;
            end
        end
        next_r.awready = !next_r.aw_held;
        next_r.wready = !next_r.w_held;
        // Read answer
        if (r.rvalid && rready) begin
            next_r.rvalid = 1'b0;
        end
        if (read_fire) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = `SCI_RESP_OKAY;
            next_r.rdata = 32'h0;
            if (araddr == `SCI_STATUS_ADDR) begin
                next_r.rdata[`SCI_EV_W-1:0] = r.status;
            end else if (araddr == `SCI_ENABLE_ADDR) begin
                next_r.rdata[`SCI_EV_W-1:0] = r.enable;
            end else begin
                next_r.rresp = `SCI_RESP_SLVERR;
            end
        end
        next_r.arready = !next_r.rvalid;
        // Sticky status, an event in the read cycle survives the clear
        next_r.status = (status_read ? '0 : r.status) | event_hit;
        // Enable gates the latched events onto the pin
        next_r.irq = |(next_r.status & next_r.enable);
    end

    // State register, all zero on reset so no enable is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops
    assign awready = r.awready;
    assign wready = r.wready;
    assign bvalid = r.bvalid;
    assign bresp = r.bresp;
    assign arready = r.arready;
    assign rvalid = r.rvalid;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    assign irq = r.irq;

    // Checks on the design's own behaviour
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic en_write;
    assign en_write = write_fire && (r.aw_addr == `SCI_ENABLE_ADDR);

    a_enable_after_reset: assert property (
        !$past(aresetn) |-> (r.enable == 5'h00 && !irq))
        else $error("enable not zero after reset");

    a_1010_raises_irq: assert property (
        event_hit[`SCI_BIT_1010] && r.enable[`SCI_BIT_1010] && !en_write
        |=> irq && r.status[`SCI_BIT_1010])
        else $error("1010 change did not raise irq");

    a_1000_raises_irq: assert property (
        event_hit[`SCI_BIT_1000] && r.enable[`SCI_BIT_1000] && !en_write
        |=> irq && r.status[`SCI_BIT_1000])
        else $error("1000 change did not raise irq");

    a_001x_raises_irq: assert property (
        event_hit[`SCI_BIT_001X] && r.enable[`SCI_BIT_001X] && !en_write
        |=> irq && r.status[`SCI_BIT_001X])
        else $error("001x change did not raise irq");

    a_001x_ignores_lsb: assert property (
        r.primed && $past(r.primed)
        && national_bit_six[3:1] == $past(national_bit_six[3:1])
        |-> !event_hit[`SCI_BIT_001X])
        else $error("001x compare saw the low bit");

    a_other_no_exit: assert property (
        r.primed && !match[`SCI_BIT_OTHER] && r.prev_match[`SCI_BIT_OTHER]
        && !r.status[`SCI_BIT_OTHER]
        |=> !r.status[`SCI_BIT_OTHER])
        else $error("leaving other value set status");

    a_irq_needs_enable: assert property (
        irq |-> |(r.status & r.enable))
        else $error("irq without enabled status");

    a_0000_raises_irq: assert property (
        event_hit[`SCI_BIT_0000] && r.enable[`SCI_BIT_0000] && !en_write
        |=> irq && r.status[`SCI_BIT_0000])
        else $error("0000 change did not raise irq");

    a_read_clears_status: assert property (
        status_read && event_hit == 5'h00 |=> r.status == 5'h00 && !irq)
        else $error("status read did not clear");

    a_set_beats_clear: assert property (
        status_read && event_hit[`SCI_BIT_0000] |=> r.status[`SCI_BIT_0000])
        else $error("event lost in read cycle");

    a_read_answer: assert property (
        read_fire |=> rvalid && r.rdata[31:`SCI_EV_W] == 27'h0)
        else $error("read not answered next cycle");

    // Handshake checks; a slave that drops an answer early hangs the master
    a_aw_refused_held: assert property (
        r.aw_held
        |-> !awready)
        else $error("awready high while address held");

    a_w_refused_held: assert property (
        r.w_held
        |-> !wready)
        else $error("wready high while data held");

    a_bvalid_stands: assert property (
        bvalid && !bready
        |=> bvalid && $stable(bresp))
        else $error("write answer dropped early");

    a_rvalid_stands: assert property (
        rvalid && !rready
        |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer dropped early");

    a_ar_refused_busy: assert property (
        rvalid
        |-> !arready)
        else $error("arready high while answer pending");

    a_write_answer: assert property (
        write_fire
        |=> bvalid)
        else $error("write not answered next cycle");

    a_unmapped_write_err: assert property (
        write_fire && r.aw_addr != `SCI_ENABLE_ADDR && r.aw_addr != `SCI_STATUS_ADDR
        |=> bresp == `SCI_RESP_SLVERR)
        else $error("unmapped write not refused");

    a_unmapped_read_err: assert property (
        read_fire && araddr != `SCI_ENABLE_ADDR && araddr != `SCI_STATUS_ADDR
        |=> rresp == `SCI_RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");

    // Register contents; only lane zero carries the enables
    a_enable_write_lands: assert property (
        en_write && r.w_lane0
        |=> r.enable == $past(r.w_data[`SCI_EV_W-1:0]))
        else $error("enable write did not land");

    a_enable_lane_off: assert property (
        en_write && !r.w_lane0
        |=> $stable(r.enable))
        else $error("enable changed with lane off");

    a_irq_matches_mask: assert property (
        irq
        == |(r.status & r.enable))
        else $error("irq differs from masked status");

    // Decode and change detection
    a_decode_onehot: assert property (
        $onehot(match))
        else $error("nibble decode not one-hot");

    a_0000_exit_event: assert property (
        r.primed && r.prev_match[`SCI_BIT_0000] && national_bit_six != 4'h0
        |-> event_hit[`SCI_BIT_0000])
        else $error("leaving 0000 made no event");

    a_other_entry_sets: assert property (
        event_hit[`SCI_BIT_OTHER]
        |=> r.status[`SCI_BIT_OTHER])
        else $error("other entry did not set status");

    a_other_move_quiet: assert property (
        r.primed && r.prev_match[`SCI_BIT_OTHER] && match[`SCI_BIT_OTHER]
        |-> !event_hit[`SCI_BIT_OTHER])
        else $error("move between other values made event");

    // Sticky status only moves on an event or a read
    a_status_holds: assert property (
        !status_read && event_hit == 5'h00
        |=> $stable(r.status))
        else $error("status moved without cause");

    a_status_read_data: assert property (
        status_read
        |=> r.rdata[`SCI_EV_W-1:0] == $past(r.status))
        else $error("status read returned wrong bits");

    c_irq_rises: cover property ($rose(irq));
    c_event_in_read: cover property (status_read && event_hit != 5'h00);
    c_status_read_hit: cover property (status_read && r.status != 5'h00);
    c_enable_written: cover property (en_write && r.w_lane0);
    c_other_entry: cover property (event_hit[`SCI_BIT_OTHER] && r.enable[`SCI_BIT_OTHER]);

endmodule

// ==== test/sci_top_bench.sv ====
// Self-checking bench for the national bit six change interrupt block.
// Assumes sci_pkg and sci_consts.svh compiled first; registers over AXI4-Lite.
`timescale 1ns/1ps
`include "sci_consts.svh"

module sci_top_bench;
    import sci_pkg::*;
    `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

    typedef struct packed {
        logic [4:0] en;
        logic [3:0] from;
        logic [3:0] to;
        logic [4:0] stat;
        logic irq;
    } sci_row_type;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] national_bit_six = 4'h0, wstrb = 4'hf;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic [1:0] rsp;
    wire logic awready, wready, bvalid, arready, rvalid, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int n_errors = 0;
    int n_checks = 0;

    // Each row: enable, nibble before, nibble after, expected status, expected irq
    sci_row_type rows [10] = '{
        '{5'h10, 4'h0, 4'ha, 5'h11, 1'b1},
        '{5'h00, 4'h5, 4'ha, 5'h10, 1'b0},
        '{5'h10, 4'ha, 4'h5, 5'h12, 1'b1},
        '{5'h08, 4'h5, 4'h8, 5'h08, 1'b1},
        '{5'h04, 4'h8, 4'h2, 5'h0c, 1'b1},
        '{5'h04, 4'h2, 4'h3, 5'h00, 1'b0},
        '{5'h02, 4'h3, 4'h6, 5'h06, 1'b1},
        '{5'h02, 4'h6, 4'h7, 5'h00, 1'b0},
        '{5'h01, 4'h7, 4'h0, 5'h01, 1'b1},
        '{5'h0d, 4'ha, 4'hf, 5'h12, 1'b0}};

    sci_top sci_top_i (.aclk(aclk), .aresetn(aresetn), .national_bit_six(national_bit_six),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));

    // 100 MHz clock
    initial begin
        forever #5 aclk = ~aclk;
    end

    task automatic final_report();
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Write: both channels offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        repeat (50) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        n_errors++;
        final_report();
    endtask

    // Read: data and response taken at the edge that sees rvalid
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        repeat (50) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        n_errors++;
        final_report();
    endtask

    // Main sequence; status is cleared before each change so rows stay independent
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`SCI_ENABLE_ADDR, rd, rsp);
        `CHK(rd, 32'h0)
        foreach (rows[k]) begin
            axi_wr(`SCI_ENABLE_ADDR, {27'h0, rows[k].en}, rsp);
            @(posedge aclk) national_bit_six <= rows[k].from;
            repeat (3) @(posedge aclk);
            axi_rd(`SCI_STATUS_ADDR, rd, rsp);
            @(posedge aclk) national_bit_six <= rows[k].to;
            repeat (3) @(posedge aclk);
            #1 `CHK(irq, rows[k].irq)
            axi_rd(`SCI_STATUS_ADDR, rd, rsp);
            `CHK(rd, {27'h0, rows[k].stat})
            #1 `CHK(irq, 1'b0)
        end
        // Upper bits are not storage; only the five enables read back
        axi_wr(`SCI_ENABLE_ADDR, 32'hffffffff, rsp);
        axi_rd(`SCI_ENABLE_ADDR, rd, rsp);
        `CHK(rd, 32'h1f)
        // Status writes are ignored; a cleared lane leaves the enables alone
        axi_wr(`SCI_STATUS_ADDR, 32'h0, rsp);
        `CHK(rsp, `SCI_RESP_OKAY)
        wstrb <= 4'he;
        axi_wr(`SCI_ENABLE_ADDR, 32'h0, rsp);
        wstrb <= 4'hf;
        `CHK(rsp, `SCI_RESP_OKAY)
        axi_rd(`SCI_ENABLE_ADDR, rd, rsp);
        `CHK(rd, 32'h1f)
        axi_wr(8'h38, 32'h0, rsp);
        `CHK(rsp, `SCI_RESP_SLVERR)
        // An unmapped read must not disturb a pending status bit
        @(posedge aclk) national_bit_six <= 4'h0;
        repeat (3) @(posedge aclk);
        axi_rd(8'h38, rd, rsp);
        `CHK({rsp, rd}, {`SCI_RESP_SLVERR, 32'h0})
        `CHK(irq, 1'b1)
        axi_rd(`SCI_STATUS_ADDR, rd, rsp);
        `CHK(rd, 32'h1)
        // Reset in mid-run drops every enable
        @(posedge aclk) aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`SCI_ENABLE_ADDR, rd, rsp);
        `CHK({rsp, rd}, {`SCI_RESP_OKAY, 32'h0})
        `CHK(irq, 1'b0)
        final_report();
    end
endmodule
